// >>> rtl/clock_gate_map.vh
`ifndef CLOCK_GATE_MAP_VH
`define CLOCK_GATE_MAP_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define STRENGTH_MODE_OFFSET 8'h0d
`define IDENT_OFFSET 8'h0e

// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define STRENGTH_MSB 7
`define STRENGTH_LSB 5
`define WIRELESS_BIT 0
`define IDENT_MSB 4
`define IDENT_LSB 0
`define STRENGTH_NORMAL 3'h5
`define STRENGTH_WIRELESS 3'h7
`define STRENGTH_MODE_RESET 8'ha0
`define IDENT_RESERVED 3'h5
`define IDENT_RESET 5'h00

// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_MHZ 50
`define PU_LATENCY_US 1800
`define PU_LATENCY_CYCLES (`PU_LATENCY_US * `CLK_MHZ)
`define DIFF_HIGH_US 300
`define DIFF_HIGH_CYCLES (`DIFF_HIGH_US * `CLK_MHZ)
`define PD_HOLD_CYCLES 4

// ----------------------------------------
// Differential drive modes
// ----------------------------------------
`define DMODE_RUN 2'h0
`define DMODE_HIGH 2'h1
`define DMODE_LOW 2'h2

`endif

// >>> rtl/sync_two_stage.v
`timescale 1ns/1ns
// ----------------------------------------
// Two flop synchroniser, per bit
// ----------------------------------------
module sync_two_stage #(
    parameter WIDTH = 1,
    parameter [WIDTH-1:0] RESET_VALUE = {WIDTH{1'b0}}
) (
    // Clock and reset
    input wire clk,
    input wire rst,
    // Data
    input wire [WIDTH-1:0] async_in,
    output reg [WIDTH-1:0] sync_out
);
    reg [WIDTH-1:0] meta; // First stage, read only by second stage

    // Both stages reset to a constant
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            meta <= RESET_VALUE;
            sync_out <= RESET_VALUE;
        end else begin
            meta <= async_in;
            sync_out <= meta;
        end
    end
endmodule

// >>> rtl/clock_output_gating_power_down.v
// Notes on behaviour
// RL1: Mode register bits 7:5 hold free PCI strength
// RL2: Wireless bit forces slew fields 111, else 101
// RL3: Identifier register bits 4:0 read zero at start
// RL4: Stops park stoppable outputs per type
// RL5: Clock request and disable drive outputs low; request lowers only stoppable non-CPU pairs, not single-ended
// RL6: Power down: single-ended low or hi-z, diff low then hi-z
// RL7: Shared pin is power good, then power down
// RL8: Power down pin synchronised internally
// RL9: Clocks held low before oscillators turn off
// RL10: Two samples, then held low at falling edge
// RL11: Platform asserts power down within 10 us
// RL12: Stable clocks within 1.8 ms of wake
// RL13: Three-stated diff outputs driven high on wake
// RL14: Outputs enable within few cycles after lock
// RL15: Reserved bits read reset values, no effect
// RL16: Free-run bit 0 free, 1 stoppable
// RL17: CPU stop parks true high, complement low
`timescale 1ns/1ns
`include "clock_gate_map.vh"

module clock_output_gating_power_down #(
    parameter N_SE = 2, // Single-ended outputs
    parameter N_DIFF = 2, // Differential pairs
    parameter [N_DIFF-1:0] DIFF_IS_CPU = 2'h1, // Pairs on CPU stop, others on PCI stop
    parameter PU_CYCLES = `PU_LATENCY_CYCLES, // Lock wait limit
    parameter DIFF_HIGH_LIMIT = `DIFF_HIGH_CYCLES // Upper bound of wake high drive
) (
    // Clock and reset
    input wire clk,
    input wire rst,
    // Platform pins, asynchronous
    input wire power_good_in, // Shared pin, later power_down_n
    input wire cpu_clock_stop_n,
    input wire pci_clock_stop_n,
    input wire clock_request_n,
    input wire strap_present,
    // Synthesiser side, same clock
    input wire pll_locked,
    input wire [N_SE-1:0] se_phase,
    input wire [N_DIFF-1:0] diff_phase,
    input wire [4:0] fuse_id,
    input wire otp_valid,
    // Per-output configuration from other bytes
    input wire [N_SE-1:0] se_enable,
    input wire [N_SE-1:0] se_stoppable,
    input wire [N_DIFF-1:0] diff_enable,
    input wire [N_DIFF-1:0] diff_stoppable,
    // Register port
    input wire [7:0] reg_addr,
    input wire reg_wr_en,
    input wire [7:0] reg_wr_data,
    input wire reg_rd_en,
    output reg [7:0] reg_rd_data,
    // Buffer configuration
    output reg [2:0] free_pci_strength,
    output reg [2:0] se_slew_code,
    // Clock outputs
    output reg [N_SE-1:0] se_clk,
    output reg [N_SE-1:0] se_oe,
    output reg [N_DIFF-1:0] diff_true,
    output reg [N_DIFF-1:0] diff_comp,
    output reg [N_DIFF-1:0] diff_oe,
    // Analog control
    output reg osc_enable,
    output reg pll_power_up
);
    // ----------------------------------------
    // States
    // ----------------------------------------
    localparam [2:0] S_WAIT_PG = 3'h0; // Pin still means power good
    localparam [2:0] S_LOCK = 3'h1; // PLL starting
    localparam [2:0] S_RUN = 3'h2; // Normal running
    localparam [2:0] S_DRAIN = 3'h3; // Holding clocks low
    localparam [2:0] S_OFF = 3'h4; // Oscillators off
    localparam [2:0] S_WAKE = 3'h5; // Diff pairs driven high

    // ----------------------------------------
    // Pin synchronisation
    // ----------------------------------------
    wire [4:0] pins_sync; // pd pin, cpu stop, pci stop, request, strap
    wire pin_high = pins_sync[0];
    wire cpu_stop = ~pins_sync[1];
    wire pci_stop = ~pins_sync[2];
    wire clk_req = ~pins_sync[3];
    wire strap_sync = pins_sync[4];

    // Stops default inactive so outputs are not parked at release
    sync_two_stage #(
        .WIDTH(5),
        .RESET_VALUE(5'h0e)
    ) u_pin_sync (
        .clk(clk),
        .rst(rst),
        .async_in({strap_present, clock_request_n, pci_clock_stop_n, cpu_clock_stop_n, power_good_in}),
        .sync_out(pins_sync)
    ); // RL8

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    reg wireless_mode; // Mode register bit 0
    reg [4:0] ident; // Identifier register bits 4:0
    reg strap_latched; // Strap caught after release

    // Mode write that changes the mode reloads the strength field with the mode default
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            free_pci_strength <= `STRENGTH_NORMAL;
            wireless_mode <= 1'b0;
            se_slew_code <= `STRENGTH_NORMAL;
            ident <= `IDENT_RESET; // RL3
        end else begin
            if (reg_wr_en && reg_addr == `STRENGTH_MODE_OFFSET) begin
                wireless_mode <= reg_wr_data[`WIRELESS_BIT];
                if (reg_wr_data[`WIRELESS_BIT] != wireless_mode) begin
                    // Mode change wins over the written code
                    free_pci_strength <= reg_wr_data[`WIRELESS_BIT] ? `STRENGTH_WIRELESS : `STRENGTH_NORMAL; // RL2
                    se_slew_code <= reg_wr_data[`WIRELESS_BIT] ? `STRENGTH_WIRELESS : `STRENGTH_NORMAL; // RL2
                end else begin
                    free_pci_strength <= reg_wr_data[`STRENGTH_MSB:`STRENGTH_LSB]; // RL1
                end
            end
            // Identifier is read only to software
            if (otp_valid) begin
                ident <= fuse_id; // RL3
            end
        end
    end

    // Registered read data, unmapped reads zero
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            reg_rd_data <= 8'h00;
        end else if (reg_rd_en) begin
            case (reg_addr)
                `STRENGTH_MODE_OFFSET: begin
                    reg_rd_data <= {free_pci_strength, 4'h0, wireless_mode}; // RL15
                end
                `IDENT_OFFSET: begin
                    reg_rd_data <= {`IDENT_RESERVED, ident}; // RL15
                end
                default: begin
                    reg_rd_data <= 8'h00;
                end
            endcase
        end
    end

    // ----------------------------------------
    // Power sequencing
    // ----------------------------------------
    reg [2:0] state;
    reg [2:0] next_state;
    reg [31:0] count; // Lock wait and hold counter
    wire [N_SE-1:0] se_held; // Per output held low
    wire all_held = &se_held;

    // Next state; the pin only counts as power down once seen high
    always @* begin
        next_state = state;
        case (state)
            S_WAIT_PG: begin
                if (pin_high) begin
                    next_state = S_LOCK; // RL7
                end
            end
            S_LOCK: begin
                if (!pin_high) begin
                    next_state = S_DRAIN; // RL11
                end else if (pll_locked || count == PU_CYCLES - 1) begin
                    next_state = S_RUN; // RL12
                end
            end
            S_RUN: begin
                if (!pin_high) begin
                    next_state = S_DRAIN; // RL7
                end
            end
            S_DRAIN: begin
                // Clocks must be parked before the oscillators go
                if (all_held && count >= `PD_HOLD_CYCLES) begin
                    next_state = S_OFF; // RL9
                end
            end
            S_OFF: begin
                if (pin_high) begin
                    next_state = S_WAKE; // RL13
                end
            end
            S_WAKE: begin
                next_state = S_LOCK;
            end
            default: begin
                next_state = S_WAIT_PG;
            end
        endcase
    end

    // State, counter, analog enables and strap capture
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            state <= S_WAIT_PG;
            count <= 32'h0;
            osc_enable <= 1'b1;
            pll_power_up <= 1'b0;
            strap_latched <= 1'b0;
        end else begin
            state <= next_state;
            count <= (next_state != state) ? 32'h0 : count + 32'h1;
            osc_enable <= (next_state != S_OFF); // RL9
            pll_power_up <= (next_state == S_LOCK) || (next_state == S_RUN); // RL12
            if (state == S_WAIT_PG) begin
                strap_latched <= strap_sync;
            end
        end
    end

    wire run_en = (state == S_RUN); // RL14
    wire pd_hold = (state == S_DRAIN) || (state == S_OFF) || (state == S_WAKE);

    // ----------------------------------------
    // Single-ended outputs
    // ----------------------------------------
    genvar i;
    generate
        for (i = 0; i < N_SE; i = i + 1) begin : g_se
            reg held;
            // Low request: not running, powering down, disabled or PCI stop
            wire want_low = ~run_en | ~se_enable[i] | (pci_stop & se_stoppable[i]); // RL4
            // Gating changes only while the phase is low, no runt pulses
            wire next_held = se_phase[i] ? held : want_low; // RL10
            assign se_held[i] = held;
            always @(posedge clk or posedge rst) begin
                if (rst) begin
                    held <= 1'b1;
                    se_clk[i] <= 1'b0;
                    se_oe[i] <= 1'b1;
                end else begin
                    held <= next_held; // RL14
                    se_clk[i] <= se_phase[i] & ~next_held; // RL5
                    // Strapped parts float their pins when off
                    se_oe[i] <= ~((next_state == S_OFF) & strap_latched); // RL6
                end
            end
        end
    endgenerate

    // ----------------------------------------
    // Differential outputs
    // ----------------------------------------
    genvar j;
    generate
        for (j = 0; j < N_DIFF; j = j + 1) begin : g_diff
            reg [1:0] mode;
            reg [1:0] want;
            wire stop_hit = DIFF_IS_CPU[j] ? cpu_stop : pci_stop;
            // Priority: off or disabled, then request, then stop
            always @* begin
                if (~run_en || ~diff_enable[j]) begin
                    want = `DMODE_LOW; // RL5
                end else if (clk_req && !DIFF_IS_CPU[j] && diff_stoppable[j]) begin
                    want = `DMODE_LOW; // RL5
                end else if (stop_hit && diff_stoppable[j]) begin
                    want = `DMODE_HIGH; // RL17
                end else begin
                    want = `DMODE_RUN; // RL16
                end
            end
            always @(posedge clk or posedge rst) begin
                if (rst) begin
                    mode <= `DMODE_LOW;
                    diff_true[j] <= 1'b0;
                    diff_comp[j] <= 1'b0;
                    diff_oe[j] <= 1'b1;
                end else begin
                    if (pd_hold) begin
                        // Power down parks both legs at once
                        mode <= `DMODE_LOW; // RL6
                    end else if (want == `DMODE_HIGH ? diff_phase[j] : ~diff_phase[j]) begin
                        // Move only where the true leg already matches
                        mode <= want; // RL4
                    end
                    if (next_state == S_WAKE) begin
                        diff_true[j] <= 1'b1; // RL13
                        diff_comp[j] <= 1'b0;
                    end else begin
                        diff_true[j] <= (mode == `DMODE_RUN) ? diff_phase[j] : (mode == `DMODE_HIGH);
                        diff_comp[j] <= (mode == `DMODE_RUN) & ~diff_phase[j];
                    end
                    diff_oe[j] <= (next_state != S_OFF); // RL6
                end
            end
        end
    endgenerate
endmodule

// >>> verification/clock_gate_chk.sv
`timescale 1ns/1ns
// ----------------------------------------
// Port checker
// ----------------------------------------
module clock_gate_chk #(
    parameter N_SE = 2,
    parameter N_DIFF = 2
) (
    // Clock and reset
    input logic clk,
    input logic rst,
    // Pins and configuration
    input logic power_good_in,
    input logic cpu_clock_stop_n,
    input logic pci_clock_stop_n,
    input logic strap_present,
    input logic [N_SE-1:0] se_enable,
    input logic [N_SE-1:0] se_stoppable,
    input logic [N_DIFF-1:0] diff_enable,
    input logic [N_DIFF-1:0] diff_stoppable,
    // Register port
    input logic [7:0] reg_addr,
    input logic reg_wr_en,
    input logic [7:0] reg_wr_data,
    input logic reg_rd_en,
    input logic [7:0] reg_rd_data,
    // Outputs
    input logic [2:0] free_pci_strength,
    input logic [2:0] se_slew_code,
    input logic [N_SE-1:0] se_clk,
    input logic [N_SE-1:0] se_oe,
    input logic [N_DIFF-1:0] diff_true,
    input logic [N_DIFF-1:0] diff_comp,
    input logic [N_DIFF-1:0] diff_oe,
    input logic osc_enable
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (rst);
    // Slew bit 1 tells the modes apart, 101 against 111
    wire rd_d = reg_rd_en && !reg_wr_en && reg_addr == 8'h0d;
    wire wr_d = reg_wr_en && reg_addr == 8'h0d;
    a_ident_reserved: assert property (reg_rd_en && reg_addr == 8'h0e |=> reg_rd_data[7:5] == 3'h5)
        else $error("ident reserved bits");
    a_unmapped_zero: assert property (reg_rd_en && reg_addr != 8'h0d && reg_addr != 8'h0e |=> reg_rd_data == 8'h00)
        else $error("unmapped read");
    a_strength_read: assert property (rd_d |=> reg_rd_data[7:5] == $past(free_pci_strength) && reg_rd_data[4:1] == 4'h0)
        else $error("strength read");
    a_mode_read: assert property (rd_d |=> se_slew_code == (reg_rd_data[0] ? 3'h7 : 3'h5))
        else $error("mode bit against slew");
    a_mode_change: assert property (wr_d && reg_wr_data[0] != se_slew_code[1]
        |=> free_pci_strength == se_slew_code && se_slew_code[1] == $past(reg_wr_data[0]))
        else $error("mode change");
    a_strength_write: assert property (wr_d && reg_wr_data[0] == se_slew_code[1]
        |=> free_pci_strength == $past(reg_wr_data[7:5]) && $stable(se_slew_code))
        else $error("strength write");
    a_low_before_off: assert property ($fell(osc_enable) |-> $past(se_clk) == 0 && $past(diff_true | diff_comp) == 0)
        else $error("clocks not low before off");
    a_pin_synced: assert property ($fell(osc_enable) |-> !$past(power_good_in, 2) && !$past(power_good_in, 4))
        else $error("power down not synchronised");
    a_off_state: assert property (!osc_enable && !power_good_in
        |-> se_clk == 0 && diff_oe == 0 && se_oe == {N_SE{!strap_present}})
        else $error("off state");
    a_wake_high: assert property ($rose(diff_oe[0]) |-> diff_true[0] && !diff_comp[0])
        else $error("wake drive");
    a_cpu_park: assert property ((!cpu_clock_stop_n && diff_stoppable[0] && diff_enable[0] && power_good_in)[*8]
        |-> diff_true[0] && !diff_comp[0])
        else $error("cpu pair not parked");
    a_pci_low: assert property ((!pci_clock_stop_n && se_stoppable[1] && se_enable[1] && power_good_in)[*6]
        |-> !se_clk[1])
        else $error("pci stop");
    a_disable_low: assert property ((!se_enable[0])[*4] |-> !se_clk[0])
        else $error("disabled output");
    c_off: cover property ($fell(osc_enable));
    c_wake: cover property ($rose(diff_oe[0]));
    c_ident: cover property (reg_rd_en && reg_addr == 8'h0e);
endmodule
bind clock_output_gating_power_down clock_gate_chk #(.N_SE(N_SE), .N_DIFF(N_DIFF)) u_chk (.clk, .rst,
    .power_good_in, .cpu_clock_stop_n, .pci_clock_stop_n, .strap_present, .se_enable, .se_stoppable,
    .diff_enable, .diff_stoppable, .reg_addr, .reg_wr_en, .reg_wr_data, .reg_rd_en, .reg_rd_data,
    .free_pci_strength, .se_slew_code, .se_clk, .se_oe, .diff_true, .diff_comp, .diff_oe, .osc_enable);

// >>> verification/platform_model.sv
`timescale 1ns/1ns
// ----------------------------------------
// Platform side of the pins
// ----------------------------------------
module platform_model #(
    parameter [7:0] PG_HOLD = 8'h14 // Hold of power good before an early power down
) (
    // Clock, reset, requests
    input wire clk,
    input wire rst,
    input wire want_up,
    input wire want_down,
    input wire want_cpu,
    input wire want_pci,
    input wire want_req,
    // Pins
    output reg power_good_in,
    output reg cpu_clock_stop_n,
    output reg pci_clock_stop_n,
    output reg clock_request_n
);
    reg [7:0] held; // Cycles seen high, saturating
    // Pins move on the rising edge; bench requests settled at the falling edge, so no race
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            power_good_in <= 1'b0;
            held <= 8'h00;
            cpu_clock_stop_n <= 1'b1;
            pci_clock_stop_n <= 1'b1;
            clock_request_n <= 1'b1;
        end else begin
            // Early power down waits the hold, far inside 10 us
            power_good_in <= want_up && !(want_down && held == PG_HOLD);
            if (power_good_in && held != PG_HOLD) begin
                held <= held + 8'h01;
            end
            cpu_clock_stop_n <= !want_cpu;
            pci_clock_stop_n <= !want_pci;
            clock_request_n <= !want_req;
        end
    end
endmodule

// >>> verification/tb_top.sv
`timescale 1ns/1ns
module tb_top;
    // ----------------------------------------
    // Signals, tables, instances
    // ----------------------------------------
    logic clk = 1'b0, rst = 1'b1, strap_present = 1'b0, pll_locked = 1'b0, otp_valid = 1'b0;
    logic reg_wr_en = 1'b0, reg_rd_en = 1'b0, want_up = 1'b0, want_down = 1'b0;
    logic want_cpu = 1'b0, want_pci = 1'b0, want_req = 1'b0;
    logic [1:0] se_phase = 2'h0, diff_phase = 2'h0, se_enable = 2'h3, se_stoppable = 2'h0;
    logic [1:0] diff_enable = 2'h3, diff_stoppable = 2'h0;
    logic [4:0] fuse_id = 5'h00;
    logic [7:0] reg_addr = 8'h00, reg_wr_data = 8'h00, reg_rd_data;
    logic [2:0] free_pci_strength, se_slew_code;
    logic [1:0] se_clk, se_oe, diff_true, diff_comp, diff_oe;
    logic osc_enable, pll_power_up, power_good_in, cpu_clock_stop_n, pci_clock_stop_n, clock_request_n;
    int miscompares = 0, check_count = 0, cycles = 0, i;
    // Register rows: write flag, address, data, expected read
    logic [24:0] reg_rows [0:12] = '{25'h0_0e_00_b3, 25'h0_0d_00_a0, 25'h1_0d_40_00, 25'h0_0d_00_40,
        25'h1_0d_01_00, 25'h0_0d_00_e1, 25'h1_0d_1f_00, 25'h0_0d_00_01, 25'h1_0e_ff_00,
        25'h0_0e_00_b3, 25'h0_0c_00_00, 25'h1_0d_00_00, 25'h0_0d_00_a0};
    // Gating rows: stops, enables, stoppables, expected probe
    logic [18:0] cfg_rows [0:4] = '{{3'h4, 16'hede4}, {3'h2, 16'hef58}, {3'h1, 16'hefd0},
        {3'h0, 16'ha790}, {3'h7, 16'hccf0}};
    clock_output_gating_power_down #(.PU_CYCLES(200)) u_dut (.clk, .rst, .power_good_in,
        .cpu_clock_stop_n, .pci_clock_stop_n, .clock_request_n, .strap_present, .pll_locked, .se_phase,
        .diff_phase, .fuse_id, .otp_valid, .se_enable, .se_stoppable, .diff_enable, .diff_stoppable,
        .reg_addr, .reg_wr_en, .reg_wr_data, .reg_rd_en, .reg_rd_data, .free_pci_strength, .se_slew_code,
        .se_clk, .se_oe, .diff_true, .diff_comp, .diff_oe, .osc_enable, .pll_power_up);
    platform_model u_plat (.clk, .rst, .want_up, .want_down, .want_cpu, .want_pci, .want_req,
        .power_good_in, .cpu_clock_stop_n, .pci_clock_stop_n, .clock_request_n);
    // Clock, phases toggling every cycle, hang guard
    always #10 clk = ~clk;
    always @(negedge clk) begin
        se_phase <= ~se_phase;
        diff_phase <= ~diff_phase;
    end
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            miscompares++;
            tally_and_finish();
        end
    end
    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
        check_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task rw(input logic [24:0] row);
        @(negedge clk);
        reg_wr_en = row[24];
        reg_rd_en = !row[24];
        reg_addr = row[23:16];
        reg_wr_data = row[15:8];
        @(negedge clk);
        reg_wr_en = 1'b0;
        reg_rd_en = 1'b0;
        if (!row[24]) chk(reg_rd_data, row[7:0], "register read");
    endtask
    // Toggle masks, then parked levels of still pairs
    task probe(input logic [7:0] exp);
        logic [1:0] s, d;
        s = se_clk;
        d = diff_true;
        @(negedge clk);
        d = d ^ diff_true;
        chk({s ^ se_clk, d, diff_true & ~d, diff_comp & ~d}, exp, "gating");
    endtask
    task tally_and_finish();
        $display("checks %0d miscompares %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // ----------------------------------------
    // Sequence
    // ----------------------------------------
    initial begin
        repeat (12) @(negedge clk);
        rst = 1'b0;
        @(negedge clk);
        chk({free_pci_strength, se_slew_code, osc_enable, pll_power_up}, 8'hb6, "reset");
        want_up = 1'b1;
        pll_locked = 1'b1;
        fuse_id = 5'h13;
        otp_valid = 1'b1;
        @(negedge clk);
        otp_valid = 1'b0;
        repeat (12) @(negedge clk);
        for (i = 0; i < 13; i++) rw(reg_rows[i]);
        for (i = 0; i < 5; i++) begin
            {want_cpu, want_pci, want_req, se_enable, se_stoppable, diff_enable, diff_stoppable} = cfg_rows[i][18:8];
            repeat (10) @(negedge clk);
            probe(cfg_rows[i][7:0]);
        end
        chk({7'h00, pll_power_up}, 8'h01, "pll on in run");
        // Power down without strap, then wake through the lock wait
        {want_cpu, want_pci, want_req, se_enable, se_stoppable, diff_enable, diff_stoppable} = 11'h0cc;
        want_down = 1'b1;
        pll_locked = 1'b0;
        for (i = 0; i < 60 && osc_enable !== 1'b0; i++) @(negedge clk);
        chk({se_clk, se_oe, diff_oe, osc_enable, pll_power_up}, 8'h30, "off");
        want_down = 1'b0;
        for (i = 0; i < 20 && diff_oe !== 2'h3; i++) @(negedge clk);
        chk({diff_true, diff_comp, 4'h0}, 8'hc0, "wake");
        repeat (215) @(negedge clk);
        probe(8'hf0);
        // Second reset: strap fitted, early power down once power good has been held 20 cycles
        rst = 1'b1;
        strap_present = 1'b1;
        want_down = 1'b1;
        pll_locked = 1'b1;
        repeat (12) @(negedge clk);
        rst = 1'b0;
        for (i = 0; i < 120 && osc_enable !== 1'b0; i++) @(negedge clk);
        chk({se_oe, diff_oe, osc_enable, 3'h0}, 8'h00, "strap off");
        tally_and_finish();
    end
endmodule
